/* src/lpic_ctrl.sv */
// Serial target, register file and command logic of the light and proximity sensor
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - seventeen byte registers, all reached over the two-wire serial target.
// - register addresses 80h to 90h, one address each.
// - answer only target address 13h.
// - low address bit is direction: 26h writes, 27h reads.
// - target works at standard, fast and high-speed rates.
// - write is start, address, register, data, stop; every byte acknowledged.
// - read sets register, repeated start, read address, one byte back, stop.
// - command register top bit reads 1 and is read-only.
// - light ready flag sets on new result, clears on reading registers 5 or 6.
// - near ready flag sets on new result, clears on reading registers 7 or 8.
// - writing 1 to bit 4 starts one light conversion into registers 5 and 6.
// - writing 1 to bit 3 starts one near conversion into registers 7 and 8.
// - bit 2 enables periodic light, bit 1 periodic near conversions.
// - bit 0 runs sequencer and oscillator; periodic needs channel enable too.
// - both single-shot bits in one write convert simultaneously.
// - single-shot requests are ignored while bit 0 is set.
module lpic_ctrl #(
  parameter logic [7:0] ID_VALUE = 8'h5a  // Arbitrary identification value
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Two-wire serial bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // Conversion engine
  output logic             light_start,
  output logic             near_start,
  input  wire logic        light_done,
  input  wire logic        near_done,
  input  wire logic [15:0] light_data,
  input  wire logic [15:0] near_data,
  // Oscillator control
  output logic             low_power_osc_en
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic in_window(input logic [7:0] addr);
    in_window = (addr >= lpic_pkg::REG_FIRST) && (addr <= lpic_pkg::REG_LAST);
  endfunction

  function automatic logic [4:0] reg_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff      = addr - lpic_pkg::REG_FIRST;
    reg_index = diff[4:0];
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  lpic_seq_if seq_bus ();

  logic                     scl_s1_reg;
  logic                     scl_s2_reg;
  logic                     scl_d_reg;
  logic                     sda_s1_reg;
  logic                     sda_s2_reg;
  logic                     sda_d_reg;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_seen;
  logic                     stop_seen;

  lpic_pkg::lpic_bus_state_t state_reg;
  logic [3:0]               bit_cnt_reg;
  logic [7:0]               rx_shift_reg;
  logic [7:0]               tx_shift_reg;
  logic [7:0]               ptr_reg;
  logic                     ptr_valid_reg;
  logic                     read_dir_reg;
  logic                     sda_hold_reg;
  logic [7:0]               rx_byte;
  logic                     wr_strobe;
  logic                     rd_strobe;
  logic [7:0]               rd_byte;
  logic [7:0]               regs_reg [lpic_pkg::REG_COUNT];

  logic                     seq_en_reg;
  logic                     light_en_reg;
  logic                     near_en_reg;
  logic                     light_od_reg;
  logic                     near_od_reg;
  logic                     light_rdy_reg;
  logic                     near_rdy_reg;
  logic                     cmd_wr;
  logic                     od_allowed;
  logic                     light_od_set;
  logic                     near_od_set;
  logic                     light_rd_clr;
  logic                     near_rd_clr;
  logic [4:0]               wr_idx;
  logic [4:0]               rd_idx;

  // ****************************************
  // Bus input synchronisers and edge detection
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg  <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
    end
  end

  // Edges are found by the core clock, so any bus rate it can sample works
  assign scl_rise   = scl_s2_reg && !scl_d_reg;
  assign scl_fall   = !scl_s2_reg && scl_d_reg;
  assign start_seen = scl_s2_reg && scl_d_reg && !sda_s2_reg && sda_d_reg;
  assign stop_seen  = scl_s2_reg && scl_d_reg && sda_s2_reg && !sda_d_reg;
  assign rx_byte    = rx_shift_reg;

  // ****************************************
  // Serial target state machine
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg     <= lpic_pkg::ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      rx_shift_reg  <= 8'h00;
      tx_shift_reg  <= 8'h00;
      ptr_reg       <= lpic_pkg::REG_FIRST;
      ptr_valid_reg <= 1'b0;
      read_dir_reg  <= 1'b0;
      sda_hold_reg  <= 1'b0;
    end else if (start_seen) begin
      // A repeated start keeps the register pointer
      state_reg     <= lpic_pkg::ST_ADDR;
      bit_cnt_reg   <= 4'h0;
      sda_hold_reg  <= 1'b0;
      ptr_valid_reg <= 1'b0;
    end else if (stop_seen) begin
      state_reg    <= lpic_pkg::ST_IDLE;
      sda_hold_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        lpic_pkg::ST_IDLE: begin
          sda_hold_reg <= 1'b0;
        end
        lpic_pkg::ST_ADDR: begin
          if (scl_rise) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == lpic_pkg::BITS_PER_BYTE) begin
            if (rx_byte[7:1] == lpic_pkg::TARGET_ADDR) begin
              read_dir_reg <= (rx_byte[0] == lpic_pkg::DIR_READ);
              sda_hold_reg <= 1'b1;
              state_reg    <= lpic_pkg::ST_ACK;
            end else begin
              state_reg <= lpic_pkg::ST_IDLE;
            end
          end
        end
        lpic_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (read_dir_reg) begin
              tx_shift_reg <= rd_byte;
              sda_hold_reg <= !rd_byte[7];
              ptr_reg      <= ptr_reg + 8'h01;
              state_reg    <= lpic_pkg::ST_TX;
            end else begin
              sda_hold_reg <= 1'b0;
              state_reg    <= lpic_pkg::ST_RX;
            end
          end
        end
        lpic_pkg::ST_RX: begin
          if (scl_rise) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == lpic_pkg::BITS_PER_BYTE) begin
            // First byte sets the pointer, later bytes write and advance it
            if (!ptr_valid_reg) begin
              ptr_reg       <= rx_byte;
              ptr_valid_reg <= 1'b1;
            end else begin
              ptr_reg <= ptr_reg + 8'h01;
            end
            sda_hold_reg <= 1'b1;
            state_reg    <= lpic_pkg::ST_ACK;
          end
        end
        lpic_pkg::ST_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == lpic_pkg::BITS_PER_BYTE) begin
              sda_hold_reg <= 1'b0;
              state_reg    <= lpic_pkg::ST_TXACK;
            end else begin
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              sda_hold_reg <= !tx_shift_reg[6];
            end
          end
        end
        lpic_pkg::ST_TXACK: begin
          // Host acknowledge asks for the next byte, no acknowledge ends the read
          if (scl_rise && sda_s2_reg) begin
            state_reg <= lpic_pkg::ST_IDLE;
          end else if (scl_fall) begin
            bit_cnt_reg  <= 4'h0;
            tx_shift_reg <= rd_byte;
            sda_hold_reg <= !rd_byte[7];
            ptr_reg      <= ptr_reg + 8'h01;
            state_reg    <= lpic_pkg::ST_TX;
          end
        end
        default: begin
          state_reg <= lpic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Open-drain data line: only ever pulled low
  assign sda_out  = 1'b0;
  assign sda_oe_n = !sda_hold_reg;

  // ****************************************
  // Register access strobes
  // ****************************************
  assign wr_strobe = (state_reg == lpic_pkg::ST_RX) && scl_fall && ptr_valid_reg &&
                     (bit_cnt_reg == lpic_pkg::BITS_PER_BYTE) && !start_seen && !stop_seen;
  assign rd_strobe = scl_fall && !start_seen && !stop_seen &&
                     (((state_reg == lpic_pkg::ST_ACK) && read_dir_reg) ||
                      ((state_reg == lpic_pkg::ST_TXACK) && !(scl_rise && sda_s2_reg)));
  assign wr_idx = reg_index(ptr_reg);
  assign rd_idx = reg_index(ptr_reg);

  // Read data for the byte at the pointer
  always_comb begin
    rd_byte = 8'h00;
    if (in_window(ptr_reg)) begin
      if (rd_idx == lpic_pkg::IDX_CMD) begin
        rd_byte[lpic_pkg::CMD_FROZEN]    = lpic_pkg::CMD_FROZEN_VAL;
        rd_byte[lpic_pkg::CMD_LIGHT_RDY] = light_rdy_reg;
        rd_byte[lpic_pkg::CMD_NEAR_RDY]  = near_rdy_reg;
        rd_byte[lpic_pkg::CMD_LIGHT_OD]  = light_od_reg;
        rd_byte[lpic_pkg::CMD_NEAR_OD]   = near_od_reg;
        rd_byte[lpic_pkg::CMD_LIGHT_EN]  = light_en_reg;
        rd_byte[lpic_pkg::CMD_NEAR_EN]   = near_en_reg;
        rd_byte[lpic_pkg::CMD_SEQ_EN]    = seq_en_reg;
      end else if (rd_idx == lpic_pkg::IDX_ID) begin
        rd_byte = ID_VALUE;
      end else begin
        rd_byte = regs_reg[rd_idx];
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < lpic_pkg::REG_COUNT; i++) begin
        regs_reg[i] <= lpic_pkg::REG_RESET;
      end
    end else begin
      if (seq_bus.light_store) begin
        regs_reg[lpic_pkg::IDX_LIGHT_HI] <= light_data[15:8];
        regs_reg[lpic_pkg::IDX_LIGHT_LO] <= light_data[7:0];
      end
      if (seq_bus.near_store) begin
        regs_reg[lpic_pkg::IDX_NEAR_HI] <= near_data[15:8];
        regs_reg[lpic_pkg::IDX_NEAR_LO] <= near_data[7:0];
      end
      // Results, identity and command are not plain storage
      if (wr_strobe && in_window(ptr_reg) && (wr_idx > lpic_pkg::IDX_NEAR_LO ||
          (wr_idx > lpic_pkg::IDX_ID && wr_idx < lpic_pkg::IDX_LIGHT_HI))) begin
        regs_reg[wr_idx] <= rx_byte;
      end
    end
  end

  // ****************************************
  // Command register
  // ****************************************
  assign cmd_wr       = wr_strobe && in_window(ptr_reg) && (wr_idx == lpic_pkg::IDX_CMD);
  // Single-shot requests are dropped while the sequencer runs or is being started
  assign od_allowed   = !seq_en_reg && !rx_byte[lpic_pkg::CMD_SEQ_EN];
  assign light_od_set = cmd_wr && od_allowed && rx_byte[lpic_pkg::CMD_LIGHT_OD];
  assign near_od_set  = cmd_wr && od_allowed && rx_byte[lpic_pkg::CMD_NEAR_OD];
  assign light_rd_clr = rd_strobe && in_window(ptr_reg) &&
                        (rd_idx == lpic_pkg::IDX_LIGHT_HI || rd_idx == lpic_pkg::IDX_LIGHT_LO);
  assign near_rd_clr  = rd_strobe && in_window(ptr_reg) &&
                        (rd_idx == lpic_pkg::IDX_NEAR_HI || rd_idx == lpic_pkg::IDX_NEAR_LO);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      seq_en_reg   <= 1'b0;
      light_en_reg <= 1'b0;
      near_en_reg  <= 1'b0;
    end else if (cmd_wr) begin
      seq_en_reg   <= rx_byte[lpic_pkg::CMD_SEQ_EN];
      light_en_reg <= rx_byte[lpic_pkg::CMD_LIGHT_EN];
      near_en_reg  <= rx_byte[lpic_pkg::CMD_NEAR_EN];
    end
  end

  // Single-shot bits stay set as a busy mark until their result lands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      light_od_reg <= 1'b0;
      near_od_reg  <= 1'b0;
    end else begin
      light_od_reg <= light_od_set || (light_od_reg && !seq_bus.light_store);
      near_od_reg  <= near_od_set || (near_od_reg && !seq_bus.near_store);
    end
  end

  // A new result in the same cycle as a clearing read keeps the flag set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      light_rdy_reg <= 1'b0;
      near_rdy_reg  <= 1'b0;
    end else begin
      light_rdy_reg <= seq_bus.light_store || (light_rdy_reg && !light_rd_clr);
      near_rdy_reg  <= seq_bus.near_store || (near_rdy_reg && !near_rd_clr);
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign seq_bus.seq_en       = seq_en_reg;
  assign seq_bus.light_en     = light_en_reg;
  assign seq_bus.near_en      = near_en_reg;
  assign seq_bus.light_od_req = light_od_set;
  assign seq_bus.near_od_req  = near_od_set;
  assign low_power_osc_en     = seq_bus.osc_run;

  lpic_seq u_seq (
    .core_clk    (core_clk),
    .rst         (rst),
    .ctl         (seq_bus.seq),
    .light_start (light_start),
    .near_start  (near_start),
    .light_done  (light_done),
    .near_done   (near_done)
  );

endmodule
`default_nettype wire

/* src/lpic_pkg.sv */
// Shared constants and types of the light and proximity control block
package lpic_pkg;

  // Serial target address and register window
  localparam logic [6:0] TARGET_ADDR   = 7'h13;
  localparam logic       DIR_READ      = 1'b1;
  localparam logic [7:0] REG_FIRST     = 8'h80;
  localparam logic [7:0] REG_LAST      = 8'h90;
  localparam int         REG_COUNT     = 17;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Register indices relative to the first register
  localparam logic [4:0] IDX_CMD      = 5'h00;
  localparam logic [4:0] IDX_ID       = 5'h01;
  localparam logic [4:0] IDX_LIGHT_HI = 5'h05;
  localparam logic [4:0] IDX_LIGHT_LO = 5'h06;
  localparam logic [4:0] IDX_NEAR_HI  = 5'h07;
  localparam logic [4:0] IDX_NEAR_LO  = 5'h08;

  // Command register field positions
  localparam int CMD_FROZEN    = 7;
  localparam int CMD_LIGHT_RDY = 6;
  localparam int CMD_NEAR_RDY  = 5;
  localparam int CMD_LIGHT_OD  = 4;
  localparam int CMD_NEAR_OD   = 3;
  localparam int CMD_LIGHT_EN  = 2;
  localparam int CMD_NEAR_EN   = 1;
  localparam int CMD_SEQ_EN    = 0;
  localparam logic CMD_FROZEN_VAL = 1'b1;

  // Sequencer timing
  localparam int CORE_CLK_HZ   = 25000000;
  localparam int LPOSC_HZ      = 100000;
  localparam int SEQ_PERIOD_US = 1000;
  localparam logic [7:0] LPOSC_DIV    = 8'(CORE_CLK_HZ / LPOSC_HZ);
  localparam logic [7:0] PERIOD_TICKS = 8'((SEQ_PERIOD_US * (LPOSC_HZ / 1000)) / 1000);

  // Serial target states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK   = 3'b010,
    ST_RX    = 3'b011,
    ST_TX    = 3'b100,
    ST_TXACK = 3'b101
  } lpic_bus_state_t;

endpackage

/* src/lpic_seq_if.sv */
// Signals between the register logic and the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
interface lpic_seq_if;
  logic seq_en;
  logic light_en;
  logic near_en;
  logic light_od_req;
  logic near_od_req;
  logic light_store;
  logic near_store;
  logic osc_run;

  modport ctrl (output seq_en, light_en, near_en, light_od_req, near_od_req,
                input light_store, near_store, osc_run);
  modport seq  (input seq_en, light_en, near_en, light_od_req, near_od_req,
                output light_store, near_store, osc_run);
endinterface
`default_nettype wire

/* src/lpic_seq.sv */
// Measurement sequencer: on-demand and self-timed conversion starts
`timescale 1ns/1ps
`default_nettype none
module lpic_seq (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Register side
  lpic_seq_if.seq   ctl,
  // Conversion engine
  output logic      light_start,
  output logic      near_start,
  input  wire logic light_done,
  input  wire logic near_done
);

  logic [7:0] osc_cnt_reg;
  logic [7:0] period_cnt_reg;
  logic       osc_tick;
  logic       period_hit;
  logic       light_busy_reg;
  logic       near_busy_reg;
  logic       light_pend_reg;
  logic       near_pend_reg;
  logic       light_go;
  logic       near_go;

  // ****************************************
  // Low-power oscillator and period timer
  // ****************************************
  assign ctl.osc_run = ctl.seq_en;
  assign osc_tick    = ctl.seq_en && (osc_cnt_reg == lpic_pkg::LPOSC_DIV - 8'h01);
  assign period_hit  = osc_tick && (period_cnt_reg == lpic_pkg::PERIOD_TICKS - 8'h01);

  always_ff @(posedge core_clk) begin
    if (rst || !ctl.seq_en || osc_tick) begin
      osc_cnt_reg <= 8'h00;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !ctl.seq_en || period_hit) begin
      period_cnt_reg <= 8'h00;
    end else if (osc_tick) begin
      period_cnt_reg <= period_cnt_reg + 8'h01;
    end
  end

  // ****************************************
  // Conversion starts
  // ****************************************
  // Periodic starts need the sequencer and the channel enable together
  assign light_go = !light_busy_reg &&
                    (ctl.seq_en ? (period_hit && ctl.light_en) : light_pend_reg);
  assign near_go  = !near_busy_reg &&
                    (ctl.seq_en ? (period_hit && ctl.near_en) : near_pend_reg);

  always_ff @(posedge core_clk) begin
    if (rst || ctl.seq_en) begin
      light_pend_reg <= 1'b0;
      near_pend_reg  <= 1'b0;
    end else begin
      light_pend_reg <= ctl.light_od_req || (light_pend_reg && !light_go);
      near_pend_reg  <= ctl.near_od_req || (near_pend_reg && !near_go);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      light_start <= 1'b0;
      near_start  <= 1'b0;
    end else begin
      light_start <= light_go;
      near_start  <= near_go;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      light_busy_reg <= 1'b0;
      near_busy_reg  <= 1'b0;
    end else begin
      light_busy_reg <= light_go || (light_busy_reg && !light_done);
      near_busy_reg  <= near_go || (near_busy_reg && !near_done);
    end
  end

  assign ctl.light_store = light_busy_reg && light_done;
  assign ctl.near_store  = near_busy_reg && near_done;

endmodule
`default_nettype wire

/* dv/lpic_chk.sv */
// Port checker of the light and proximity control block
`timescale 1ns/1ps
`default_nettype none
module lpic_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Sequencer outputs
  input wire logic light_start,
  input wire logic near_start,
  input wire logic low_power_osc_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  out_zero_a: assert property (sda_out == 1'b0)
    else $error("serial data value not low");
  rst_quiet_a: assert property (disable iff (1'b0) rst |=> sda_oe_n && !light_start
    && !near_start && !low_power_osc_en) else $error("outputs active after reset");
  light_pulse_a: assert property (light_start |=> !light_start)
    else $error("light start longer than one cycle");
  near_pulse_a: assert property (near_start |=> !near_start)
    else $error("near start longer than one cycle");
  seq_no_shot_a: assert property ($rose(low_power_osc_en)
    |-> (!light_start && !near_start) [*8]) else $error("shot taken with sequencer on");
  ack_in_low_a: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 2))
    else $error("data line pulled while clock high");
  ack_stands_a: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*4])
    else $error("driven bit released too early");
  osc_in_low_a: assert property ($changed(low_power_osc_en) |-> !$past(scl_in))
    else $error("oscillator enable moved outside a write");
  shot_on_write_a: assert property (light_start && !low_power_osc_en
    |-> !$past(scl_in, 2)) else $error("light shot not tied to a write");
endmodule

bind lpic_ctrl lpic_chk u_chk (.core_clk, .rst, .scl_in, .sda_out, .sda_oe_n,
  .light_start, .near_start, .low_power_osc_en);
`default_nettype wire

/* dv/lpic_host.sv */
// Host bus master model driving the two-wire serial bus
`timescale 1ns/1ps
`default_nettype none
module lpic_host (
  // Clock
  input  wire logic core_clk,
  // Bus lines
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Start when post is 0, stop when post is 1; clock stands high afterwards
  task automatic bus_cond(input logic post);
    scl <= 1'b0;
    tick(4);
    sda <= !post;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda <= post;
    tick(4);
  endtask
  // One bit: 6 cycles low, 2 high, data moved 4 cycles after the fall
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(4);
    sda <= b;
    tick(2);
    scl <= 1'b1;
    tick(1);
    r = sda_line;
    tick(1);
  endtask
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic reg_write(input logic [7:0] dev, a, d, output logic ok);
    logic [7:0] rx;
    logic k1, k2, k3;
    bus_cond(1'b0);
    byte_io(dev, rx, k1);
    byte_io(a, rx, k2);
    byte_io(d, rx, k3);
    bus_cond(1'b1);
    ok = k1 & k2 & k3;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic k1, k2, k3, k4;
    bus_cond(1'b0);
    byte_io(8'h26, rx, k1);
    byte_io(a, rx, k2);
    bus_cond(1'b0);
    byte_io(8'h27, rx, k3);
    byte_io(8'hff, d, k4);
    bus_cond(1'b1);
    ok = k1 & k2 & k3;
  endtask
endmodule
`default_nettype wire

/* dv/lpic_ctrl_test.sv */
// Self-checking bench of the light and proximity control block
`timescale 1ns/1ps
`default_nettype none
module lpic_ctrl_test;
  localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identification value
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl, sda, sda_out, sda_oe_n, light_start, near_start, low_power_osc_en;
  logic        light_done = 1'b0;
  logic        near_done = 1'b0;
  logic [15:0] light_data = 16'h0000;
  logic [15:0] near_data = 16'h0000;
  int          n_mismatch, samples_checked, n_light, n_near, t_light, t_near, cyc;
  wire logic   sda_line = sda & (sda_oe_n | sda_out);

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (light_start === 1'b1) begin
      n_light <= n_light + 1;
      t_light <= cyc;
    end
    if (near_start === 1'b1) begin
      n_near <= n_near + 1;
      t_near <= cyc;
    end
  end

  lpic_ctrl #(.ID_VALUE(ID_VAL)) u_dut (.core_clk, .rst, .scl_in(scl), .sda_in(sda_line),
    .sda_out, .sda_oe_n, .light_start, .near_start, .light_done, .near_done,
    .light_data, .near_data, .low_power_osc_en);
  lpic_host u_host (.core_clk, .sda_line, .scl, .sda);

  task automatic check(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic ok;
    u_host.reg_write(8'h26, a, d, ok);
    check({15'h0000, ok}, 16'h0001);
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    logic [7:0] d;
    logic ok;
    u_host.reg_read(a, d, ok);
    check({7'h00, ok, d}, {8'h01, exp});
  endtask
  task automatic pulse(input logic l, n);
    light_done <= l;
    near_done <= n;
    @(posedge core_clk);
    light_done <= 1'b0;
    near_done <= 1'b0;
  endtask

  task automatic t_regs();
    logic ok;
    rd_chk(8'h80, 8'h80);
    rd_chk(8'h81, ID_VAL);
    wr(8'h84, 8'ha5);
    rd_chk(8'h84, 8'ha5);
    wr(8'h90, 8'h5c);
    rd_chk(8'h90, 8'h5c);
    wr(8'h91, 8'h77);
    rd_chk(8'h91, 8'h00);
    wr(8'h80, 8'he0);
    rd_chk(8'h80, 8'h80);
    u_host.reg_write(8'h28, 8'h84, 8'h11, ok);
    check({15'h0000, ok}, 16'h0000);
    rd_chk(8'h84, 8'ha5);
  endtask

  task automatic t_shots();
    light_data <= 16'h1234;
    near_data <= 16'hbeef;
    wr(8'h80, 8'h18);
    check(16'(n_light), 16'h0001);
    check(16'(n_near), 16'h0001);
    check(16'(t_light), 16'(t_near));
    rd_chk(8'h80, 8'h98);
    pulse(1'b1, 1'b1);
    rd_chk(8'h80, 8'he0);
    rd_chk(8'h87, 8'hbe);
    rd_chk(8'h80, 8'hc0);
    rd_chk(8'h86, 8'h34);
    rd_chk(8'h80, 8'h80);
    light_data <= 16'h5678;
    wr(8'h80, 8'h10);
    check(16'(n_light + 16 * n_near), 16'h0012);
    pulse(1'b1, 1'b0);
    rd_chk(8'h80, 8'hc0);
    rd_chk(8'h85, 8'h56);
    rd_chk(8'h80, 8'h80);
  endtask

  task automatic t_seq();
    int w;
    wr(8'h80, 8'h19);
    check({15'h0000, low_power_osc_en}, 16'h0001);
    rd_chk(8'h80, 8'h81);
    repeat (26000) @(posedge core_clk);
    check(16'(n_light + 16 * n_near), 16'h0012);
    wr(8'h80, 8'h1f);
    check(16'(n_light + 16 * n_near), 16'h0012);
    rd_chk(8'h80, 8'h87);
    for (w = 0; w < 26000 && (n_light < 3 || n_near < 2); w++) @(posedge core_clk);
    check(16'(n_light + 16 * n_near), 16'h0023);
    wr(8'h80, 8'h00);
    check({15'h0000, low_power_osc_en}, 16'h0000);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_regs();
    t_shots();
    t_seq();
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
